// ---- supply_monitor_consts.vh ----
`ifndef SUPPLY_MONITOR_CONSTS_VH
`define SUPPLY_MONITOR_CONSTS_VH

// register byte offsets
`define SM_CONTROL_OFFSET 8'h00
`define SM_STATUS_OFFSET 8'h04

// control field positions
`define SM_CIRCUIT_EN_BIT 7
`define SM_THRESHOLD_SEL_BIT 3
`define SM_RESET_EN_BIT 2
`define SM_FALL_IE_BIT 1
`define SM_RISE_IE_BIT 0

// status field positions
`define SM_FALL_FLAG_BIT 1
`define SM_RISE_FLAG_BIT 0

// fixed-one reserved bits and reset values
`define SM_CONTROL_RSVD_ONES 8'h70
`define SM_STATUS_RSVD_ONES 8'hFC
`define SM_CONTROL_RESET 8'h00
`define SM_STATUS_RESET 8'h00

// cycles counted after supply recovery before the internal reset releases
`define SM_RELEASE_CYCLES 131072

// axi responses
`define SM_RESP_OKAY 2'b00
`define SM_RESP_SLVERR 2'b10

`endif

// ---- release_counter.v ----
`timescale 1ns/1ns
`default_nettype none
module release_counter #(
	parameter integer COUNT = 131072,
	parameter integer COUNT_W = 18
)
(
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// control
	input wire clear,
	input wire run,
	// status
	output wire done
);
	reg [COUNT_W-1:0] count_reg;
	reg [COUNT_W-1:0] count_next;
	localparam integer LAST_INT = COUNT - 1;
	localparam [COUNT_W-1:0] LAST = LAST_INT[COUNT_W-1:0];

	assign done = run && (count_reg == LAST);

	always @*
	begin
		count_next = count_reg;
		if (clear || done)
			count_next = {COUNT_W{1'b0}};
		else if (run)
			count_next = count_reg + {{(COUNT_W-1){1'b0}}, 1'b1};
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
			count_reg <= {COUNT_W{1'b0}};
		else
			count_reg <= count_next;
	end
endmodule // release_counter
`default_nettype wire

// ---- supply_monitor.v ----
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "supply_monitor_consts.vh"

// Overview of operation
// - enable bit 7 clear keeps detection in standby; set activates it
// - control bits 6 to 4 always read one; writes ignored
// - bit 3 selects reset threshold: zero 2.3 V, one 3.6 V
// - bit 2 gates generation of the low-voltage reset
// - bit 1 permits the supply-fall interrupt; clear suppresses it
// - bit 0 permits the supply-rise interrupt; clear suppresses it
// - bits 7, 3, 2 survive low-voltage reset; cleared only by full reset
// - fall flag sets on fall; cleared by reading one then writing zero
// - after recovery, count 131,072 cycles before releasing internal reset
module supply_monitor #(
	parameter integer RELEASE_CYCLES = `SM_RELEASE_CYCLES,
	parameter integer RELEASE_W = 18
)
(
	// clock and power-on / watchdog reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address and data
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// comparator levels from the analog supervisor
	input wire supply_below_reset,
	input wire supply_below_fall,
	input wire supply_above_rise,
	// to the analog supervisor and system
	output wire monitor_active,
	output wire threshold_high,
	output reg internal_reset_n,
	output wire supply_irq
);
	reg circuit_en_reg;
	reg threshold_sel_reg;
	reg reset_en_reg;
	reg fall_ie_reg;
	reg rise_ie_reg;
	reg fall_flag_reg;
	reg rise_flag_reg;
	reg fall_seen_reg;
	reg rise_seen_reg;
	reg rise_armed_reg;
	reg below_fall_d_reg;
	reg above_rise_d_reg;
	reg lv_reset_reg;
	wire wr_fire;
	wire rd_fire;
	wire wr_ctrl;
	wire wr_stat;
	wire rd_ctrl;
	wire rd_stat;
	wire fall_event;
	wire rise_event;
	wire fall_clear;
	wire rise_clear;
	wire lv_trip;
	wire release_done;
	wire [7:0] control_view;
	wire [7:0] status_view;

	assign monitor_active = circuit_en_reg;
	assign threshold_high = threshold_sel_reg;

	// write taken only with address and data both offered
	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_wready = s_axi_awready;
	assign wr_fire = s_axi_awready;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign wr_ctrl = wr_fire && s_axi_wstrb[0] && (s_axi_awaddr[7:2] == `SM_CONTROL_OFFSET >> 2);
	assign wr_stat = wr_fire && s_axi_wstrb[0] && (s_axi_awaddr[7:2] == `SM_STATUS_OFFSET >> 2);
	assign rd_ctrl = rd_fire && (s_axi_araddr[7:2] == `SM_CONTROL_OFFSET >> 2);
	assign rd_stat = rd_fire && (s_axi_araddr[7:2] == `SM_STATUS_OFFSET >> 2);

	assign control_view = `SM_CONTROL_RSVD_ONES
		| ({7'h00, circuit_en_reg} << `SM_CIRCUIT_EN_BIT)
		| ({7'h00, threshold_sel_reg} << `SM_THRESHOLD_SEL_BIT)
		| ({7'h00, reset_en_reg} << `SM_RESET_EN_BIT)
		| ({7'h00, fall_ie_reg} << `SM_FALL_IE_BIT)
		| ({7'h00, rise_ie_reg} << `SM_RISE_IE_BIT);
	assign status_view = `SM_STATUS_RSVD_ONES
		| ({7'h00, fall_flag_reg} << `SM_FALL_FLAG_BIT)
		| ({7'h00, rise_flag_reg} << `SM_RISE_FLAG_BIT);

	// detection events only while the circuit is in use
	assign fall_event = circuit_en_reg && supply_below_fall && !below_fall_d_reg;
	assign rise_event = circuit_en_reg && rise_armed_reg && supply_above_rise && !above_rise_d_reg;
	assign fall_clear = wr_stat && !s_axi_wdata[`SM_FALL_FLAG_BIT] && fall_seen_reg;
	assign rise_clear = wr_stat && !s_axi_wdata[`SM_RISE_FLAG_BIT] && rise_seen_reg;
	assign lv_trip = circuit_en_reg && reset_en_reg && supply_below_reset;

	assign supply_irq = (fall_flag_reg && fall_ie_reg) || (rise_flag_reg && rise_ie_reg);

	release_counter #(
		.COUNT(RELEASE_CYCLES),
		.COUNT_W(RELEASE_W)
	) u_release (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(supply_below_reset),
		.run(lv_reset_reg && !supply_below_reset),
		.done(release_done)
	);

	// low-voltage reset: held while low, released after the recovery count
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lv_reset_reg <= 1'b0;
			internal_reset_n <= 1'b1;
		end
		else
		begin
			if (lv_trip)
				lv_reset_reg <= 1'b1;
			else if (release_done)
				lv_reset_reg <= 1'b0;
			internal_reset_n <= !(lv_trip || (lv_reset_reg && !release_done));
		end
	end

	// control bits; circuit, threshold and reset enables survive low-voltage reset
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			circuit_en_reg <= 1'b0;
			threshold_sel_reg <= 1'b0;
			reset_en_reg <= 1'b0;
			fall_ie_reg <= 1'b0;
			rise_ie_reg <= 1'b0;
		end
		else if (lv_reset_reg)
		begin
			fall_ie_reg <= 1'b0;
			rise_ie_reg <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			circuit_en_reg <= s_axi_wdata[`SM_CIRCUIT_EN_BIT];
			threshold_sel_reg <= s_axi_wdata[`SM_THRESHOLD_SEL_BIT];
			reset_en_reg <= s_axi_wdata[`SM_RESET_EN_BIT];
			fall_ie_reg <= s_axi_wdata[`SM_FALL_IE_BIT];
			rise_ie_reg <= s_axi_wdata[`SM_RISE_IE_BIT];
		end
	end

	// status flags; a new event wins over a clear in the same cycle
	always @(posedge aclk)
	begin
		if (!aresetn || lv_reset_reg)
		begin
			fall_flag_reg <= 1'b0;
			rise_flag_reg <= 1'b0;
			fall_seen_reg <= 1'b0;
			rise_seen_reg <= 1'b0;
			rise_armed_reg <= 1'b0;
			below_fall_d_reg <= 1'b0;
			above_rise_d_reg <= 1'b0;
		end
		else
		begin
			below_fall_d_reg <= supply_below_fall;
			above_rise_d_reg <= supply_above_rise;
			if (fall_event)
				fall_flag_reg <= 1'b1;
			else if (fall_clear)
				fall_flag_reg <= 1'b0;
			if (rise_event)
				rise_flag_reg <= 1'b1;
			else if (rise_clear)
				rise_flag_reg <= 1'b0;
			// a rise counts only after a fall seen with rise interrupt enabled
			if (fall_event && rise_ie_reg)
				rise_armed_reg <= 1'b1;
			else if (rise_event || !circuit_en_reg)
				rise_armed_reg <= 1'b0;
			// read-as-one latch that permits a later clearing write
			if (wr_stat || fall_event)
				fall_seen_reg <= 1'b0;
			else if (rd_stat && fall_flag_reg)
				fall_seen_reg <= 1'b1;
			if (wr_stat || rise_event)
				rise_seen_reg <= 1'b0;
			else if (rd_stat && rise_flag_reg)
				rise_seen_reg <= 1'b1;
		end
	end

	// bus answers, one cycle after acceptance
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SM_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `SM_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end
		else
		begin
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (s_axi_awaddr[7:2] == `SM_CONTROL_OFFSET >> 2 ||
					s_axi_awaddr[7:2] == `SM_STATUS_OFFSET >> 2) ? `SM_RESP_OKAY : `SM_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (rd_fire)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= (rd_ctrl || rd_stat) ? `SM_RESP_OKAY : `SM_RESP_SLVERR;
				if (rd_ctrl)
					s_axi_rdata <= {24'h00_0000, control_view};
				else if (rd_stat)
					s_axi_rdata <= {24'h00_0000, status_view};
				else
					s_axi_rdata <= 32'h0000_0000;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // supply_monitor
`default_nettype wire

// ---- supply_monitor_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module supply_monitor_chk (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	// supervisor
	input wire logic supply_below_reset,
	input wire logic monitor_active,
	input wire logic threshold_high,
	input wire logic internal_reset_n,
	input wire logic supply_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire logic wr_ctl = s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h00 && s_axi_wstrb[0] && internal_reset_n;
	enable_follow_a: assert property (wr_ctl |=> monitor_active == $past(s_axi_wdata[7]))
		else $error("enable bit not applied");
	level_follow_a: assert property (wr_ctl |=> threshold_high == $past(s_axi_wdata[3]))
		else $error("level bit not applied");
	fixed_ones_a: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr) == 8'h00 |-> s_axi_rdata[6:4] == 3'b111)
		else $error("fixed bits not one");
	irq_masked_a: assert property (wr_ctl && s_axi_wdata[1:0] == 2'b00 |=> !supply_irq)
		else $error("irq with enables off");
	reset_cause_a: assert property ($fell(internal_reset_n) |-> $past(supply_below_reset) && $past(monitor_active))
		else $error("reset without cause");
	reset_hold_a: assert property (!internal_reset_n && supply_below_reset |=> !internal_reset_n)
		else $error("reset left while low");
	release_wait_a: assert property ($fell(supply_below_reset) && !internal_reset_n |-> !internal_reset_n [*7] ##[1:6] internal_reset_n)
		else $error("release count wrong");
	bits_kept_a: assert property (!internal_reset_n |=> $stable(monitor_active) && $stable(threshold_high))
		else $error("kept bits changed");
endmodule // supply_monitor_chk
bind supply_monitor supply_monitor_chk chk (.*);
`default_nettype wire

// ---- low_voltage_detect_control_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CK(n, e, a) \
	begin \
		cmp_count++; \
		if ((a) !== (e)) \
		begin \
			$display("CHECK FAILED %s exp %0h got %0h", n, e, a); \
			n_errors++; \
		end \
	end
`define WT(c) \
	begin \
		k = 0; \
		do @(posedge aclk); while (!(c) && ++k < 99); \
		if (!(c)) \
		begin \
			n_errors++; \
			end_sim; \
		end \
	end
module low_voltage_detect_control_test;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic s_axi_bready = 1, s_axi_rready = 1, supply_below_reset = 0, supply_below_fall = 0, supply_above_rise = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic monitor_active, threshold_high, internal_reset_n, supply_irq;
	int n_errors = 0, cmp_count = 0, k;
	// release count shortened for simulation; settle is about 50 us at 4 ns
	localparam int REL_CYCLES = 8;
	localparam int SETTLE = 12500;
	supply_monitor #(.RELEASE_CYCLES(REL_CYCLES)) dut (.*);
	initial forever #2 aclk = ~aclk;
	task end_sim;
		$display("errors %0d checks %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		`WT(s_axi_awready && s_axi_wready)
		s_axi_awvalid <= 0;
		s_axi_wvalid <= 0;
		`WT(s_axi_bvalid)
		rsp = s_axi_bresp;
	endtask
	task rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		`WT(s_axi_arready)
		s_axi_arvalid <= 0;
		`WT(s_axi_rvalid)
		rdat = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	task settle;
		repeat (SETTLE) @(posedge aclk);
	endtask
	task fall;
		supply_below_fall <= 1;
		repeat (2) @(posedge aclk);
		supply_below_fall <= 0;
		repeat (2) @(posedge aclk);
	endtask
	task t_regs;
		rd(8'h00);
		`CK("ctl rst", 32'h0000_0070, rdat)
		wr(8'h00, 32'hFFFF_FFF8); // circuit first, reset enable later
		rd(8'h00);
		`CK("ctl ones", 32'h0000_00F8, rdat)
		`CK("active", 1'b1, monitor_active)
		`CK("level", 1'b1, threshold_high)
		settle;
		wr(8'h00, 32'h0000_008C); // reset only, high level
		rd(8'h00);
		`CK("ctl rst on", 32'h0000_00FC, rdat)
		wr(8'h00, 32'h0000_0088); // reset enable cleared before circuit enable
		wr(8'h00, 32'h0000_0000);
		rd(8'h00);
		`CK("ctl zero", 32'h0000_0070, rdat)
		`CK("standby", 1'b0, monitor_active)
		wr(8'h08, 32'h0000_0001);
		`CK("bad wr", 2'b10, rsp)
		rd(8'h08);
		`CK("bad rd", 2'b10, rsp)
	endtask
	task t_flags;
		fall;
		rd(8'h04);
		`CK("stat off", 32'h0000_00FC, rdat)
		wr(8'h00, 32'h0000_0083); // both interrupts use the low level
		fall;
		`CK("irq fall", 1'b1, supply_irq)
		supply_above_rise <= 1;
		@(posedge aclk);
		supply_above_rise <= 0;
		rd(8'h04);
		`CK("stat set", 32'h0000_00FF, rdat)
		wr(8'h04, 32'h0000_0000);
		rd(8'h04);
		`CK("stat clr", 32'h0000_00FC, rdat)
		settle;
		wr(8'h00, 32'h0000_008C); // reset only after the circuit settled
		fall;
		`CK("irq off", 1'b0, supply_irq)
	endtask
	task t_lvr;
		wr(8'h00, 32'h0000_0082); // reset enable off, fall interrupt only
		supply_below_reset <= 1;
		repeat (3) @(posedge aclk);
		`CK("no rst", 1'b1, internal_reset_n)
		wr(8'h00, 32'h0000_008C);
		repeat (3) @(posedge aclk);
		`CK("rst", 1'b0, internal_reset_n)
		supply_below_reset <= 0;
		`WT(internal_reset_n)
		`CK("release", REL_CYCLES, k)
		rd(8'h00);
		`CK("kept", 32'h0000_00FC, rdat)
	endtask
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		t_regs;
		t_flags;
		t_lvr;
		end_sim;
	end
endmodule // low_voltage_detect_control_test
`default_nettype wire
